//--- rtl/csi_top.v
// battery-good and open-drain indicator logic of the charger
`include "csi_map.vh"

module csi_top #(
  parameter PULSE_CYC = `CSI_PULSE_CYC,
  parameter WDOG_CYC  = `CSI_WDOG_CYC
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // register port
  input  wire [4:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // charger core, same clock
  input  wire        i_chg_active,
  input  wire        i_vbat_min_ok,
  input  wire [9:0]  i_vbat_code,
  input  wire        i_fault,
  input  wire [2:0]  i_fault_code,
  // battery presence sense pin
  input  wire        i_batt_absent,
  // pins
  output reg         o_battery_good_n,
  output reg         o_ind_o,
  output reg         o_ind_oe_n,
  output reg         o_charge_enable_n,
  output reg         o_irq
);

  //////////////////////////////////////////////////////////////////////////
  localparam ST_OFF  = 3'b001;
  localparam ST_PRE  = 3'b010;
  localparam ST_FAST = 3'b100;

  function [9:0] thr_code;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    thr_code = `CSI_VBAT_THR0;
        2'h1:    thr_code = `CSI_VBAT_THR1;
        2'h2:    thr_code = `CSI_VBAT_THR2;
        default: thr_code = `CSI_VBAT_THR3;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         absent_s1_reg;
  reg         absent_s2_reg;
  reg  [1:0]  thr_sel_reg;
  reg         ind_en_reg;
  reg         wdog_dis_reg;
  reg         force_reg;
  reg         ce_n_reg;
  reg  [2:0]  fault_reg;
  reg         above_reg;
  reg  [31:0] wdog_cnt_reg;
  reg         wdog_exp_reg;
  reg  [15:0] pulse_cnt_reg;
  reg  [2:0]  irq_sts_reg;
  reg  [2:0]  irq_msk_reg;
  reg         good_n_next;
  reg  [7:0]  rdata_next;

  wire wr_ctrl  = i_wr && (i_addr == `CSI_REG_CTRL);
  wire wr_cfg   = i_wr && (i_addr == `CSI_REG_CFG);
  wire wr_mon   = i_wr && (i_addr == `CSI_REG_MON);
  wire wr_wdog  = i_wr && (i_addr == `CSI_REG_WDOG);
  wire wr_sts   = i_wr && (i_addr == `CSI_REG_IRQ_STS);
  wire wr_msk   = i_wr && (i_addr == `CSI_REG_IRQ_MSK);
  wire restart  = wr_ctrl && i_wdata[`CSI_CTRL_RESTART];
  wire wdog_clr = restart || (wr_wdog && i_wdata[`CSI_WDOG_DIS]);
  wire charging = (state_reg != ST_OFF);
  wire wdog_hit = !wdog_dis_reg && charging && !wdog_exp_reg &&
                  (wdog_cnt_reg == WDOG_CYC - 1);
  wire good_chg = (good_n_next != o_battery_good_n);
  wire pulse_rq = i_fault || good_chg || wdog_hit;

  //////////////////////////////////////////////////////////////////////////
  // battery presence pin synchroniser
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      absent_s1_reg <= 1'b0;
      absent_s2_reg <= 1'b0;
    end else begin
      absent_s1_reg <= i_batt_absent;
      absent_s2_reg <= absent_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // charge state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        if (i_chg_active && !wdog_exp_reg)
          state_next = ST_PRE;
      ST_PRE:
        if (!i_chg_active || wdog_hit)
          state_next = ST_OFF;
        else if (i_vbat_min_ok)
          state_next = ST_FAST;
      ST_FAST:
        if (!i_chg_active || wdog_hit)
          state_next = ST_OFF;
        else if (i_vbat_code < `CSI_VBAT_3V0)
          state_next = ST_PRE;
      default:
        state_next = ST_OFF;
    endcase
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // threshold crossing latched for the length of one fast charge
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      above_reg <= 1'b0;
    end else if (state_reg != ST_FAST) begin
      above_reg <= 1'b0;
    end else if (i_vbat_code >= thr_code(thr_sel_reg)) begin
      above_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // battery-good pin, also the status bit mirror
  always @* begin
    good_n_next = 1'b1;
    if (state_reg == ST_FAST && above_reg)
      good_n_next = 1'b0;
    if (wdog_exp_reg || force_reg)
      good_n_next = 1'b1;
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_battery_good_n <= 1'b1;
    end else begin
      o_battery_good_n <= good_n_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host watchdog: pauses outside charging, restarts on each restart write
  // expiry holds until a restart or disable write; expiry wins a tie
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdog_cnt_reg <= 32'h0;
      wdog_exp_reg <= 1'b0;
    end else if (wdog_hit) begin
      wdog_cnt_reg <= 32'h0;
      wdog_exp_reg <= 1'b1;
    end else if (wdog_clr) begin
      wdog_cnt_reg <= 32'h0;
      wdog_exp_reg <= 1'b0;
    end else if (wdog_dis_reg) begin
      wdog_cnt_reg <= 32'h0;
    end else if (charging && !wdog_exp_reg) begin
      wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers; watchdog expiry returns them to defaults
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      thr_sel_reg  <= `CSI_THR_RST;
      ind_en_reg   <= 1'b0;
      wdog_dis_reg <= `CSI_WDOG_DIS_RST;
      force_reg    <= 1'b0;
      ce_n_reg     <= 1'b1;
    end else if (wdog_hit) begin
      thr_sel_reg  <= `CSI_THR_RST;
      ind_en_reg   <= 1'b0;
      wdog_dis_reg <= `CSI_WDOG_DIS_RST;
      force_reg    <= 1'b0;
      ce_n_reg     <= 1'b1;
    end else begin
      if (wr_ctrl)
        ind_en_reg <= i_wdata[`CSI_CTRL_IND_EN];
      if (wr_cfg) begin
        thr_sel_reg <= i_wdata[`CSI_CFG_THR_HI:`CSI_CFG_THR_LO];
        ce_n_reg    <= i_wdata[2];
      end
      if (wr_mon)
        force_reg <= i_wdata[`CSI_MON_GOOD];
      if (wr_wdog)
        wdog_dis_reg <= i_wdata[`CSI_WDOG_DIS];
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_charge_enable_n <= 1'b1;
    end else begin
      o_charge_enable_n <= ce_n_reg;
    end
  end

  // fault type from the core in any charge state, watchdog expiry reported as its own code
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_reg <= 3'h0;
    end else if (wdog_hit) begin
      fault_reg <= `CSI_FAULT_WDOG;
    end else if (i_fault) begin
      fault_reg <= i_fault_code;
    end else if (restart) begin
      fault_reg <= 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // indicator pulse timer
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_cnt_reg <= 16'h0;
    end else if (pulse_rq) begin
      pulse_cnt_reg <= PULSE_CYC[15:0];
    end else if (pulse_cnt_reg != 16'h0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h1;
    end
  end

  // open drain: output low, enable low while pulling the pin
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ind_o    <= 1'b0;
      o_ind_oe_n <= 1'b1;
    end else begin
      o_ind_o    <= 1'b0;
      o_ind_oe_n <= !(pulse_rq || (pulse_cnt_reg > 16'h1) ||
                      (ind_en_reg && charging));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one-to-clear
  wire [2:0] irq_set = {wdog_hit, good_chg, i_fault};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sts
      always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          irq_sts_reg[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_sts_reg[gi] <= 1'b1;
        end else if (wr_sts && i_wdata[gi]) begin
          irq_sts_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_msk_reg <= 3'h0;
      o_irq       <= 1'b0;
    end else begin
      if (wr_msk)
        irq_msk_reg <= i_wdata[2:0];
      o_irq <= |(irq_sts_reg & irq_msk_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, unmapped addresses read zero
  always @* begin
    rdata_next = 8'h00;
    case (i_addr)
      `CSI_REG_CTRL:
        rdata_next = {1'b0, ind_en_reg, 3'h0, fault_reg};
      `CSI_REG_CFG:
        rdata_next = {2'h0, thr_sel_reg, 1'b0, ce_n_reg, 2'h0};
      `CSI_REG_MON:
        rdata_next = {2'h0, o_battery_good_n, 1'b0,
                      absent_s2_reg, 3'h0};
      `CSI_REG_WDOG:
        rdata_next = {6'h0, wdog_dis_reg, 1'b0};
      `CSI_REG_IRQ_STS:
        rdata_next = {5'h0, irq_sts_reg};
      `CSI_REG_IRQ_MSK:
        rdata_next = {5'h0, irq_msk_reg};
      default:
        rdata_next = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // csi_top

//--- rtl/csi_map.vh
// register map, field positions, reset values and timing of the indicator
`ifndef CSI_MAP_VH
`define CSI_MAP_VH
`define CSI_ADDR_W        5
`define CSI_REG_CTRL      5'h00
`define CSI_REG_CFG       5'h01
`define CSI_REG_MON       5'h11
`define CSI_REG_WDOG      5'h13
`define CSI_REG_IRQ_STS   5'h14
`define CSI_REG_IRQ_MSK   5'h15
`define CSI_CTRL_RESTART  7
`define CSI_CTRL_IND_EN   6
`define CSI_CFG_THR_HI    5
`define CSI_CFG_THR_LO    4
`define CSI_MON_GOOD      5
`define CSI_MON_ABSENT    3
`define CSI_WDOG_DIS      1
`define CSI_THR_RST       2'h3
`define CSI_WDOG_DIS_RST  1'h1
`define CSI_FAULT_WDOG    3'h6
`define CSI_IRQ_FAULT     0
`define CSI_IRQ_GOOD      1
`define CSI_IRQ_WDOG      2
// battery code: 5 mV per lsb
`define CSI_VBAT_3V0      10'h258
`define CSI_VBAT_THR0     10'h2a8
`define CSI_VBAT_THR1     10'h2bc
`define CSI_VBAT_THR2     10'h2d0
`define CSI_VBAT_THR3     10'h2e4
`define CSI_CLK_MHZ       100
`define CSI_PULSE_NS      128000
`define CSI_PULSE_CYC     (`CSI_PULSE_NS * `CSI_CLK_MHZ / 1000)
`define CSI_WDOG_S        32
`define CSI_WDOG_CYC      (`CSI_WDOG_S * `CSI_CLK_MHZ * 32'h000f4240)
`endif

//--- dv/csi_chk.sv
// assertions on the battery-good, indicator and read data ports
`include "csi_map.vh"
module csi_chk (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_chg_active,
  input wire logic [9:0] i_vbat_code,
  input wire logic       i_fault,
  input wire logic       o_battery_good_n,
  input wire logic       o_ind_o,
  input wire logic       o_ind_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_off_not_good: assert property (!i_chg_active |-> ##2 o_battery_good_n)
    else $error("battery good while not charging");
  a_weak_stays_high: assert property (o_battery_good_n &&
    i_vbat_code < `CSI_VBAT_THR0 && $past(i_vbat_code) < `CSI_VBAT_THR0
    |=> o_battery_good_n) else $error("battery good below threshold");
  a_low_bat_high: assert property (i_vbat_code < `CSI_VBAT_3V0
    |-> ##2 o_battery_good_n) else $error("battery good below 3.0 V");
  a_force_high: assert property (i_wr && i_addr == `CSI_REG_MON
    && i_wdata[5] |-> ##2 o_battery_good_n)
    else $error("forced high write ignored");
  a_change_pulse: assert property ($changed(o_battery_good_n)
    |-> !o_ind_oe_n) else $error("no pulse on good pin change");
  a_ind_data_low: assert property (o_ind_o == 1'b0)
    else $error("indicator data driven high");
  a_fault_pulse: assert property (i_fault |=> !o_ind_oe_n [*8])
    else $error("fault pulse too short");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // csi_chk

//--- dv/csi_host_model.sv
// host side of the register port
module csi_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [4:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 5'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // host writes: force latch, charge enable, watchdog restart
  task automatic wr(input logic [4:0] a, input logic [7:0] dat);
    @(posedge i_clk) begin
      o_addr <= a;
      o_wdata <= dat;
      o_wr <= 1'b1;
    end
    @(posedge i_clk) o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] dat);
    @(posedge i_clk) begin
      o_addr <= a;
      o_rd <= 1'b1;
    end
    @(posedge i_clk) o_rd <= 1'b0;
    #1 dat = i_rdata;
  endtask
endmodule // csi_host_model

//--- dv/tb_csi_top.sv
// self-checking bench of the indicator block
`include "csi_map.vh"
module tb_csi_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst_n = 0, chg = 0, vok = 0, flt = 0, absent = 0;
  logic [9:0] code = 10'h000;
  logic [2:0] fcode = 3'h0;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, d;
  logic       wr, rd, good_n, ind_o, ind_oe_n, ce_n, irq;
  int         n_mismatch = 0, samples_checked = 0;
  logic [9:0] thr [4] = '{`CSI_VBAT_THR0, `CSI_VBAT_THR1,
                          `CSI_VBAT_THR2, `CSI_VBAT_THR3};
  csi_host_model i_csi_host_model (.i_clk(clk), .i_rdata(rdata),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  csi_top #(.PULSE_CYC(8), .WDOG_CYC(50)) i_csi_top (.i_clk(clk),
    .i_nrst(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_chg_active(chg), .i_vbat_min_ok(vok),
    .i_vbat_code(code), .i_fault(flt), .i_fault_code(fcode),
    .i_batt_absent(absent), .o_battery_good_n(good_n), .o_ind_o(ind_o),
    .o_ind_oe_n(ind_oe_n), .o_charge_enable_n(ce_n), .o_irq(irq));
  initial forever #5 clk = ~clk;
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task final_report;
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("good_n", 1, good_n);
    chk("ind_oe_n", 1, ind_oe_n);
    chk("ce_n", 1, ce_n);
    chk("irq", 0, irq);
    i_csi_host_model.rd(`CSI_REG_CFG, d);
    chk("cfg", 8'h34, d & 8'h34);
    i_csi_host_model.rd(`CSI_REG_WDOG, d);
    chk("wdog_dis", 1, d[1]);
    i_csi_host_model.rd(5'h1f, d);
    chk("unmapped", 0, d);
  endtask
  task t_fault;
    i_csi_host_model.wr(`CSI_REG_IRQ_MSK, 8'h01);
    for (int f = 1; f < 6; f++) begin
      @(posedge clk) begin flt <= 1; fcode <= f[2:0]; end
      @(posedge clk) flt <= 0;
      w(0);
      chk("ind_oe_n", 0, ind_oe_n);
      i_csi_host_model.rd(`CSI_REG_CTRL, d);
      chk("fault", f, d[2:0]);
      chk("irq", 1, irq);
      w(2);
      @(posedge clk) flt <= 1;
      @(posedge clk) flt <= 0;
      w(6);
      chk("restart", 0, ind_oe_n);
      w(4);
      chk("released", 1, ind_oe_n);
      i_csi_host_model.wr(`CSI_REG_IRQ_STS, 8'h07);
      w(2);
      chk("irq clr", 0, irq);
    end
  endtask
  task t_thr;
    for (int s = 0; s < 4; s++) begin
      i_csi_host_model.wr(`CSI_REG_CFG, {2'b00, s[1:0], 4'h0});
      w(2);
      chk("ce_n", 0, ce_n);
      @(posedge clk) begin chg <= 1; vok <= 0; code <= thr[s]; end
      w(4);
      chk("pre", 1, good_n);
      @(posedge clk) begin vok <= 1; code <= thr[s] - 1; end
      w(4);
      chk("below thr", 1, good_n);
      @(posedge clk) code <= thr[s];
      w(3);
      chk("at thr", 0, good_n);
      i_csi_host_model.rd(`CSI_REG_MON, d);
      chk("mon good", 0, d[5]);
      @(posedge clk) code <= `CSI_VBAT_3V0;
      w(8);
      chk("fast hold", 0, good_n);
      @(posedge clk) code <= `CSI_VBAT_3V0 - 1;
      w(3);
      chk("below 3v0", 1, good_n);
      @(posedge clk) vok <= 0;
    end
  endtask
  task t_force_ind;
    @(posedge clk) begin vok <= 1; code <= `CSI_VBAT_THR3; end
    w(4);
    i_csi_host_model.wr(`CSI_REG_MON, 8'h20);
    w(3);
    chk("forced", 1, good_n);
    i_csi_host_model.wr(`CSI_REG_MON, 8'h00);
    w(3);
    chk("unforced", 0, good_n);
    i_csi_host_model.wr(`CSI_REG_CTRL, 8'h40);
    w(12);
    chk("ind chg", 0, ind_oe_n);
    i_csi_host_model.wr(`CSI_REG_CTRL, 8'h00);
    w(12);
    chk("ind open", 1, ind_oe_n);
    @(posedge clk) absent <= 1;
    w(4);
    i_csi_host_model.rd(`CSI_REG_MON, d);
    chk("absent", 1, d[3]);
  endtask
  task t_wdog;
    i_csi_host_model.wr(`CSI_REG_WDOG, 8'h00);
    repeat (4) begin
      w(30);
      i_csi_host_model.wr(`CSI_REG_CTRL, 8'h80);
    end
    chk("kept alive", 0, good_n);
    w(60);
    chk("expired", 1, good_n);
    i_csi_host_model.rd(`CSI_REG_CTRL, d);
    chk("wdog fault", `CSI_FAULT_WDOG, d[2:0]);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    w(1);
    t_reset();
    t_fault();
    t_thr();
    t_force_ind();
    t_wdog();
    final_report();
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule // tb_csi_top
bind csi_top csi_chk i_csi_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_chg_active(i_chg_active), .i_vbat_code(i_vbat_code),
  .i_fault(i_fault), .o_battery_good_n(o_battery_good_n),
  .o_ind_o(o_ind_o), .o_ind_oe_n(o_ind_oe_n));
